/* File: hw/uart_ch_pkg.sv */
// Constants, types and helpers shared by the serial channel and its receive engine.
// Assumes one system clock and an I/O strobe bus from the CPU core.
package uart_ch_pkg;
    localparam logic [7:0] OFS_CTLA0 = 8'h00;
    localparam logic [7:0] OFS_CTLA1 = 8'h01;
    localparam logic [7:0] OFS_CTLB0 = 8'h02;
    localparam logic [7:0] OFS_CTLB1 = 8'h03;
    localparam logic [7:0] OFS_SERIAL_STATUS_CH0 = 8'h04;
    localparam logic [7:0] OFS_SERIAL_STATUS_CH1 = 8'h05;
    localparam logic [7:0] OFS_TDR0  = 8'h06;
    localparam logic [7:0] OFS_TDR1  = 8'h07;
    localparam logic [7:0] OFS_RDR0  = 8'h08;
    localparam logic [7:0] OFS_RDR1  = 8'h09;
    // Status bits
    localparam int S_RXF = 7;
    localparam int S_OVR = 6;
    localparam int S_PE  = 5;
    localparam int S_FE  = 4;
    localparam int S_RIE = 3;
    localparam int S_DCD = 2;
    localparam int S_TXE = 1;
    localparam int S_TIE = 0;
    // Control A bits
    localparam int A_MPE = 7;
    localparam int A_RE  = 6;
    localparam int A_TE  = 5;
    localparam int A_B4  = 4;
    localparam int A_EFR = 3;
    localparam int A_M2  = 2;
    localparam int A_M1  = 1;
    localparam int A_M0  = 0;
    // Control B bits
    localparam int B_MP_BIT_TX_VALUE = 7;
    localparam int B_MP   = 6;
    localparam int B_CTS  = 5;
    localparam int B_PEO  = 4;
    localparam logic [7:0] CTLA0_RST = 8'h10;
    localparam logic [7:0] CTLA1_RST = 8'h00;
    localparam logic [7:0] CTLB_RST  = 8'h07;
    localparam int OVERSAMPLE = 16;
    localparam int CNT_W      = 6;
    localparam int FRAME_W    = 12;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} rx_state_type;
    typedef enum logic {TX_IDLE, TX_RUN} tx_state_type;
    // Parity bit that makes the count even, inverted for odd
    function automatic logic par_of(input logic [7:0] d, input logic odd);
        par_of = (^d) ^ odd;
    endfunction
endpackage

/* File: hw/rx_link_if.sv */
// Link between the channel's register logic and its receive engine.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface rx_link_if;
    logic       samp_tick;
    logic       rxd;
    logic       hold;
    logic       wide;
    logic       par_en;
    logic       two_stop;
    logic       mp_fmt;
    logic       parity_odd_select;
    logic       done;
    logic [7:0] data;
    logic       fe;
    logic       pe;
    logic       multiproc_flag_bit;
    modport engine (input samp_tick, rxd, hold, wide, par_en, two_stop, mp_fmt, parity_odd_select,
                    output done, data, fe, pe, multiproc_flag_bit);
    modport ctrl (output samp_tick, rxd, hold, wide, par_en, two_stop, mp_fmt, parity_odd_select,
                  input done, data, fe, pe, multiproc_flag_bit);
endinterface

/* File: hw/uart_rx_engine.sv */
// Receive shift engine: assembles one frame and reports it with its error bits.
// Assumes rxd is already synchronised and samp_tick is a one-cycle oversampling strobe.
`timescale 1ns/1ns
module uart_rx_engine
    import uart_ch_pkg::*;
#(
    parameter int OVS = OVERSAMPLE
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    rx_link_if.engine lk
);
    rx_state_type     st_r;
    logic [CNT_W-1:0] cnt_r;
    logic [3:0]       bit_r;
    logic [7:0]       sh_r;
    logic             xb_r;
    logic             fe_r;
    logic             stop2_r;
    logic             done_r;
    logic [7:0]       data_r;
    logic             fe_o_r;
    logic             pe_o_r;
    logic             mpb_r;

    wire logic             has_ex   = lk.par_en | lk.mp_fmt;
    wire logic [3:0]       last_bit = lk.wide ? 4'h7 : 4'h6;
    // start bit checked at half a bit, then every full bit
    wire logic [CNT_W-1:0] goal     = (st_r == RX_START) ? CNT_W'(OVS / 2 - 1) : CNT_W'(OVS - 1);
    wire logic             samp     = lk.samp_tick && (cnt_r == goal);
    wire logic [7:0]       dat      = lk.wide ? sh_r : {1'b0, sh_r[7:1]};

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r    <= RX_IDLE;
            cnt_r   <= '0;
            bit_r   <= '0;
            sh_r    <= '0;
            xb_r    <= 1'b0;
            fe_r    <= 1'b0;
            stop2_r <= 1'b0;
            done_r  <= 1'b0;
            data_r  <= '0;
            fe_o_r  <= 1'b0;
            pe_o_r  <= 1'b0;
            mpb_r   <= 1'b0;
        end
        else if (lk.hold)
        begin
            st_r   <= RX_IDLE;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (lk.samp_tick)
                cnt_r <= samp ? '0 : cnt_r + 1'b1;
            unique case (st_r)
                RX_IDLE:
                    if (!lk.rxd)
                    begin
                        st_r    <= RX_START;
                        cnt_r   <= '0;
                        fe_r    <= 1'b0;
                        stop2_r <= 1'b0;
                        bit_r   <= '0;
                    end
                RX_START:
                    if (samp)
                        st_r <= lk.rxd ? RX_IDLE : RX_DATA;
                RX_DATA:
                    if (samp)
                    begin
                        sh_r  <= {lk.rxd, sh_r[7:1]};
                        bit_r <= bit_r + 1'b1;
                        if (bit_r == last_bit)
                            st_r <= has_ex ? RX_EXTRA : RX_STOP;
                    end
                RX_EXTRA:
                    if (samp)
                    begin
                        xb_r <= lk.rxd;
                        st_r <= RX_STOP;
                    end
                RX_STOP:
                    if (samp)
                    begin
                        if (lk.two_stop && !stop2_r)
                        begin
                            stop2_r <= 1'b1;
                            fe_r    <= fe_r | !lk.rxd;
                        end
                        else
                        begin
                            st_r   <= RX_IDLE;
                            done_r <= 1'b1;
                            data_r <= dat;
                            fe_o_r <= fe_r | !lk.rxd;
                            pe_o_r <= lk.par_en & !lk.mp_fmt & (par_of(dat, lk.parity_odd_select) ^ xb_r);
                            mpb_r  <= xb_r;
                        end
                    end
            endcase
        end
    end

    assign lk.done = done_r;
    assign lk.data = data_r;
    assign lk.fe   = fe_o_r;
    assign lk.pe   = pe_o_r;
    assign lk.multiproc_flag_bit  = mpb_r;
endmodule // uart_rx_engine

/* File: hw/async_serial_status_control.sv */
// One asynchronous serial channel: registers, flags, modem lines and transmitter.
// Assumes CPU I/O strobes and samp_tick come from clk_sys logic; pins are asynchronous.
`timescale 1ns/1ns
module async_serial_status_control
    import uart_ch_pkg::*;
#(
    parameter bit IS_CH0 = 1'b1,
    parameter int OVS    = OVERSAMPLE
)
(
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    output logic [7:0]      io_rdata,
    input  wire logic       io_halt_mode,
    input  wire logic       samp_tick,
    input  wire logic       rxd_pin,
    output logic            txd,
    input  wire logic       carrier_detect_ch0,
    input  wire logic       cts_pin,
    output logic            request_to_send_ch0,
    output logic            ch1_ext_clock_pin_disable,
    output logic            sync_serial_rx_data,
    output logic            irq_req
);
    localparam logic [7:0] CTLA_OFS = IS_CH0 ? OFS_CTLA0 : OFS_CTLA1;
    localparam logic [7:0] CTLB_OFS = IS_CH0 ? OFS_CTLB0 : OFS_CTLB1;
    localparam logic [7:0] STAT_OFS = IS_CH0 ? OFS_SERIAL_STATUS_CH0 : OFS_SERIAL_STATUS_CH1;
    localparam logic [7:0] TDR_OFS  = IS_CH0 ? OFS_TDR0 : OFS_TDR1;
    localparam logic [7:0] RDR_OFS  = IS_CH0 ? OFS_RDR0 : OFS_RDR1;
    localparam logic [7:0] CTLA_RST = IS_CH0 ? CTLA0_RST : CTLA1_RST;

    logic [2:0]         s1_r;
    logic [2:0]         s2_r;
    logic               dcd_d_r;
    logic [7:0]         ctla_r;
    logic [7:0]         ctlb_r;
    logic               rie_r;
    logic               tie_r;
    logic               cts_sel_r;
    logic               rx_full_r;
    logic               ovr_r;
    logic               pe_r;
    logic               fe_r;
    logic               dcd_stat_r;
    logic               dcd_rise_r;
    logic               mp_rx_r;
    logic [7:0]         rx_holding_reg;
    logic [7:0]         tx_holding_reg;
    logic               tx_full_r;
    logic [7:0]         rdata_r;
    tx_state_type       tx_st_r;
    logic [FRAME_W-1:0] tx_shift_reg;
    logic [3:0]         tx_left_r;
    logic [CNT_W-1:0]   tx_cnt_r;
    logic               txd_r;

    rx_link_if lk ();

    uart_rx_engine #(
        .OVS (OVS)
    ) u_rx (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .lk      (lk)
    );

    // Pin synchronisers: bit 0 rxd, 1 carrier, 2 clear-to-send
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r <= 3'b001;
            s2_r <= 3'b001;
        end
        else
        begin
            s1_r <= {cts_pin, carrier_detect_ch0, rxd_pin};
            s2_r <= s1_r;
        end
    end

    wire logic halt    = io_halt_mode;
    wire logic wr_ctla = io_wr && (io_addr == CTLA_OFS);
    wire logic wr_ctlb = io_wr && (io_addr == CTLB_OFS);
    wire logic wr_stat = io_wr && (io_addr == STAT_OFS);
    wire logic wr_tdr  = io_wr && (io_addr == TDR_OFS);
    wire logic wr_rdr  = io_wr && (io_addr == RDR_OFS);
    wire logic rd_stat = io_rd && (io_addr == STAT_OFS);
    wire logic rd_rdr  = io_rd && (io_addr == RDR_OFS);

    wire logic dcd_s    = IS_CH0 ? s2_r[1] : 1'b0;
    wire logic cts_s    = IS_CH0 ? s2_r[2] : (cts_sel_r & s2_r[2]);
    wire logic dcd_hold = dcd_stat_r;
    // Flags stay cleared until the status read that follows the carrier fall
    wire logic clr_all  = dcd_hold | halt;
    wire logic mp_fmt   = ctlb_r[B_MP];

    assign lk.samp_tick = samp_tick;
    assign lk.rxd       = s2_r[0];
    assign lk.hold      = !ctla_r[A_RE] | dcd_hold | halt;
    assign lk.wide      = ctla_r[A_M2];
    assign lk.par_en    = ctla_r[A_M1];
    assign lk.two_stop  = ctla_r[A_M0];
    assign lk.mp_fmt    = mp_fmt;
    assign lk.parity_odd_select       = ctlb_r[B_PEO];

    wire logic acc      = lk.done & !(mp_fmt & ctla_r[A_MPE] & !lk.multiproc_flag_bit);
    // Reading the holding register in the same cycle frees it for the new byte
    wire logic load     = acc & (!rx_full_r | rd_rdr);
    wire logic ovr_set  = acc & rx_full_r & !rd_rdr;
    wire logic efr_clr  = wr_ctla & !io_wdata[A_EFR];
    wire logic tx_empty = !tx_full_r & !cts_s;
    wire logic tx_tick  = samp_tick && (tx_cnt_r == CNT_W'(OVS - 1));
    wire logic tx_move  = tx_full_r && (tx_st_r == TX_IDLE) && ctla_r[A_TE];

    // Control registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctla_r    <= CTLA_RST;
            ctlb_r    <= CTLB_RST;
            rie_r     <= 1'b0;
            tie_r     <= 1'b0;
            cts_sel_r <= 1'b0;
        end
        else
        begin
            if (wr_ctla)
                ctla_r <= io_wdata;
            if (halt)
            begin
                ctla_r[A_RE] <= 1'b0;
                ctla_r[A_TE] <= 1'b0;
            end
            if (wr_ctlb)
                ctlb_r <= io_wdata;
            if (wr_stat)
            begin
                rie_r     <= io_wdata[S_RIE];
                tie_r     <= io_wdata[S_TIE];
                cts_sel_r <= io_wdata[S_DCD];
            end
        end
    end

    // Receive side flags; a set always beats a clear from software
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_full_r      <= 1'b0;
            ovr_r          <= 1'b0;
            pe_r           <= 1'b0;
            fe_r           <= 1'b0;
            mp_rx_r        <= 1'b0;
            rx_holding_reg <= '0;
        end
        else
        begin
            if (clr_all)
                rx_full_r <= 1'b0;
            else if (load)
                rx_full_r <= 1'b1;
            else if (rd_rdr)
                rx_full_r <= 1'b0;
            if (load)
                rx_holding_reg <= lk.data;
            else if (wr_rdr && !rx_full_r)
                rx_holding_reg <= io_wdata;
            if (clr_all)
            begin
                ovr_r <= 1'b0;
                pe_r  <= 1'b0;
                fe_r  <= 1'b0;
            end
            else
            begin
                ovr_r <= ovr_set | (ovr_r & !efr_clr);
                pe_r  <= (load & lk.pe) | (pe_r & !efr_clr);
                fe_r  <= (load & lk.fe) | (fe_r & !efr_clr);
            end
            if (lk.done && mp_fmt)
                mp_rx_r <= lk.multiproc_flag_bit;
        end
    end

    // Carrier status and its rising edge
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dcd_d_r    <= 1'b0;
            dcd_stat_r <= 1'b0;
            dcd_rise_r <= 1'b0;
        end
        else
        begin
            dcd_d_r <= dcd_s;
            if (dcd_s)
                dcd_stat_r <= 1'b1;
            else if (rd_stat)
                dcd_stat_r <= 1'b0;
            dcd_rise_r <= (dcd_s & !dcd_d_r) | (dcd_rise_r & !rd_stat);
        end
    end

    // frame image, start bit at bit 0
    function automatic logic [FRAME_W+3:0] tx_frame(input logic [7:0] d,
                                                    input logic [7:0] a,
                                                    input logic [7:0] b);
        logic [FRAME_W-1:0] f;
        logic [7:0]         dm;
        logic               ex;
        logic               xb;
        f  = {3'b111, d, 1'b0};
        dm = a[A_M2] ? d : {1'b0, d[6:0]};
        ex = a[A_M1] | b[B_MP];
        xb = b[B_MP] ? b[B_MP_BIT_TX_VALUE] : par_of(dm, b[B_PEO]);
        if (a[A_M2])
            f[9] = ex ? xb : 1'b1;
        else
            f[8] = ex ? xb : 1'b1;
        // Count runs from start bit through last stop, so back-to-back frames keep their stop
        tx_frame = {4'(4'd9 + {3'b000, a[A_M2]} + {3'b000, ex} + {3'b000, a[A_M0]}), f};
    endfunction

    wire logic [FRAME_W+3:0] frame = tx_frame(tx_holding_reg, ctla_r, ctlb_r);

    // Transmit holding register and shifter
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_full_r      <= 1'b0;
            tx_holding_reg <= '0;
            tx_st_r        <= TX_IDLE;
            tx_shift_reg   <= '1;
            tx_left_r      <= '0;
            tx_cnt_r       <= '0;
            txd_r          <= 1'b1;
        end
        else
        begin
            // write fills flag, move empties it
            if (halt)
                tx_full_r <= 1'b0;
            else if (wr_tdr)
                tx_full_r <= 1'b1;
            else if (tx_move)
                tx_full_r <= 1'b0;
            if (wr_tdr)
                tx_holding_reg <= io_wdata;
            if (samp_tick)
                tx_cnt_r <= tx_tick ? '0 : tx_cnt_r + 1'b1;
            if (!ctla_r[A_TE] || halt)
            begin
                tx_st_r <= TX_IDLE;
                txd_r   <= 1'b1;
            end
            else if (tx_move)
            begin
                tx_st_r      <= TX_RUN;
                txd_r        <= frame[0];
                tx_shift_reg <= {1'b1, frame[FRAME_W-1:1]};
                tx_left_r    <= frame[FRAME_W+3:FRAME_W] - 1'b1;
                tx_cnt_r     <= '0;
            end
            // lsb first, one bit per period
            else if (tx_st_r == TX_RUN && tx_tick)
            begin
                if (tx_left_r == '0)
                begin
                    tx_st_r <= TX_IDLE;
                    txd_r   <= 1'b1;
                end
                else
                begin
                    txd_r        <= tx_shift_reg[0];
                    tx_shift_reg <= {1'b1, tx_shift_reg[FRAME_W-1:1]};
                    tx_left_r    <= tx_left_r - 1'b1;
                end
            end
        end
    end

    wire logic [7:0] stat_v = {rx_full_r, ovr_r, pe_r, fe_r, rie_r,
                               IS_CH0 ? dcd_stat_r : cts_sel_r, tx_empty, tie_r};
    wire logic [7:0] ctla_v = {ctla_r[7:4], mp_rx_r, ctla_r[2:0]};
    wire logic [7:0] ctlb_v = {ctlb_r[7:6], cts_s, ctlb_r[4:0]};
    wire logic [7:0] rd_mux = (io_addr == STAT_OFS) ? stat_v :
                              (io_addr == CTLA_OFS) ? ctla_v :
                              (io_addr == CTLB_OFS) ? ctlb_v :
                              (io_addr == TDR_OFS)  ? tx_holding_reg :
                              (io_addr == RDR_OFS)  ? rx_holding_reg : 8'h00;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= '0;
        else if (io_rd)
            rdata_r <= rd_mux;
    end

    assign io_rdata = rdata_r;
    assign txd = txd_r;
    assign request_to_send_ch0 = IS_CH0 ? ctla_r[A_B4] : 1'b1;
    assign ch1_ext_clock_pin_disable = IS_CH0 ? 1'b0 : ctla_r[A_B4];
    assign sync_serial_rx_data = s2_r[2];
    assign irq_req = (rie_r & (rx_full_r | ovr_r | pe_r | fe_r | dcd_rise_r)) | (tie_r & tx_empty);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_rx_full_set: assert property (load && !clr_all |=> rx_full_r)
        else $error("full flag not set");
    a_rx_full_clr: assert property (clr_all || (rd_rdr && !load) |=> !rx_full_r)
        else $error("full flag not cleared");
    a_overrun_set: assert property (ovr_set && !clr_all |=> ovr_r)
        else $error("overrun missed");
    a_error_reset: assert property (efr_clr && !lk.done |=> !ovr_r && !pe_r && !fe_r)
        else $error("error flags not reset");
    a_rx_irq_req: assert property (rie_r && (rx_full_r || fe_r) |-> irq_req)
        else $error("receive interrupt missing");
    a_dcd_sticky: assert property (dcd_stat_r && !dcd_s && !rd_stat |=> dcd_stat_r)
        else $error("carrier status lost early");
    a_dcd_hold_rx: assert property (dcd_stat_r |=> !rx_full_r && !ovr_r)
        else $error("receiver not held");
    a_tx_write: assert property (wr_tdr && !halt |=> !tx_empty ##1 1'b1)
        else $error("empty flag not cleared");
    a_tx_idle_high: assert property (tx_st_r == TX_IDLE |-> txd)
        else $error("line not idle high");
    a_halt_off: assert property (halt |=> !ctla_r[A_RE] && !ctla_r[A_TE] && !tx_full_r)
        else $error("halt did not stop channel");
    a_rts_follow: assert property (wr_ctla && IS_CH0 |=> request_to_send_ch0 == $past(io_wdata[A_B4]))
        else $error("request-to-send not driven");
endmodule // async_serial_status_control

/* File: tb/remote_uart.sv */
// Remote serial peer: drives frames into rxd_pin, captures 8-bit txd frames.
// Assumes one bit lasts 16 clk_sys cycles (samp_tick every cycle).
`timescale 1ns/1ns
module remote_uart
(
    input  wire logic clk_sys,
    input  wire logic txd,
    output logic      rxd_pin
);
    logic [7:0] rx_byte;
    initial rxd_pin = 1'b1;
    // start, then lsb first, then stop
    task automatic send(input logic [8:0] bits, input int n, input logic stop);
        for (int i = -1; i <= n; i++)
        begin
            rxd_pin = (i < 0) ? 1'b0 : (i == n) ? stop : bits[i];
            repeat (16) @(negedge clk_sys);
        end
        rxd_pin = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    // mid-bit sampling of the device's frames
    initial forever
    begin
        @(negedge txd);
        repeat (8) @(negedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(negedge clk_sys);
            rx_byte[i] = txd;
        end
        repeat (16) @(negedge clk_sys);
    end
endmodule // remote_uart

/* File: tb/tb_top.sv */
// Self-checking bench for channel 0: registers, receive flags, modem lines, transmit.
// Assumes remote_uart as line peer; samp_tick tied high so one bit is 16 clocks.
`timescale 1ns/1ns
module tb_top;
    import uart_ch_pkg::*;
    logic       clk_sys, arst_n, io_wr, io_rd, halt, dcd, cts, txd, rxd, rts, cka, srx, irq;
    logic [7:0] io_addr, io_wdata, io_rdata, b;
    int         failures = 0;
    int         checks_done = 0;
    int         rxq[$];
    async_serial_status_control i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_halt_mode(halt),
        .samp_tick(1'b1), .rxd_pin(rxd), .txd(txd), .carrier_detect_ch0(dcd), .cts_pin(cts),
        .request_to_send_ch0(rts), .ch1_ext_clock_pin_disable(cka), .sync_serial_rx_data(srx), .irq_req(irq));
    remote_uart i_peer (.clk_sys(clk_sys), .txd(txd), .rxd_pin(rxd));
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic wr);
        io_addr = a;
        io_wdata = d;
        io_wr = wr;
        io_rd = ~wr;
        @(negedge clk_sys);
        io_wr = 1'b0;
        io_rd = 1'b0;
        // One idle cycle so the next access never re-raises a strobe in the same step
        @(negedge clk_sys);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        acc(a, 8'h00, 1'b0);
        chk(io_rdata, exp);
    endtask
    task automatic rxb(input logic stop);
        b = 8'($urandom);
        rxq.push_back(int'(b));
        i_peer.send({1'b0, b}, 8, stop);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(negedge clk_sys);
        failures++;
        end_of_test;
    end
    initial
    begin
        {arst_n, io_wr, io_rd, halt, dcd, cts} = '0;
        io_addr = 8'h00;
        io_wdata = 8'h00;
        void'($urandom(12));
        repeat (5) @(negedge clk_sys);
        arst_n = 1'b1;
        rdc(OFS_CTLA0, 8'h10);
        rdc(OFS_CTLB0, 8'h07);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h02);
        chk({7'h00, txd}, 8'h01);
        chk({7'h00, rts}, 8'h01);
        chk({7'h00, cka}, 8'h00);
        acc(OFS_CTLA0, 8'h64, 1'b1);
        chk({7'h00, rts}, 8'h00);
        rxb(1'b1);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h82);
        rdc(OFS_RDR0, 8'(rxq.pop_front()));
        rdc(OFS_SERIAL_STATUS_CH0, 8'h02);
        rxb(1'b1);
        rxb(1'b1);
        rdc(OFS_SERIAL_STATUS_CH0, 8'hC2);
        rdc(OFS_RDR0, 8'(rxq[0]));
        rxq.delete();
        acc(OFS_CTLA0, 8'h64, 1'b1);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h02);
        rxb(1'b0);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h92);
        rdc(OFS_RDR0, 8'(rxq.pop_front()));
        acc(OFS_CTLA0, 8'h66, 1'b1);
        b = 8'($urandom);
        i_peer.send({~(^b), b}, 9, 1'b1);
        rdc(OFS_SERIAL_STATUS_CH0, 8'hA2);
        rdc(OFS_RDR0, b);
        acc(OFS_CTLA0, 8'h64, 1'b1);
        b = 8'($urandom);
        acc(OFS_TDR0, b, 1'b1);
        repeat (200) @(negedge clk_sys);
        chk(i_peer.rx_byte, b);
        acc(OFS_SERIAL_STATUS_CH0, 8'h01, 1'b1);
        chk({7'h00, irq}, 8'h01);
        cts = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({7'h00, srx}, 8'h01);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h01);
        chk({7'h00, irq}, 8'h00);
        cts = 1'b0;
        acc(OFS_SERIAL_STATUS_CH0, 8'h08, 1'b1);
        acc(OFS_CTLB0, 8'h47, 1'b1);
        acc(OFS_CTLA0, 8'hE4, 1'b1);
        b = 8'($urandom);
        i_peer.send({1'b0, b}, 9, 1'b1);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h0A);
        chk({7'h00, irq}, 8'h00);
        i_peer.send({1'b1, b}, 9, 1'b1);
        chk({7'h00, irq}, 8'h01);
        rdc(OFS_CTLA0, 8'hEC);
        rdc(OFS_RDR0, b);
        acc(OFS_CTLB0, 8'h07, 1'b1);
        acc(OFS_CTLA0, 8'h64, 1'b1);
        rxb(1'b1);
        dcd = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({7'h00, irq}, 8'h01);
        rxb(1'b1);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h0E);
        dcd = 1'b0;
        repeat (4) @(negedge clk_sys);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h0E);
        rdc(OFS_SERIAL_STATUS_CH0, 8'h0A);
        chk({7'h00, irq}, 8'h00);
        halt = 1'b1;
        @(negedge clk_sys);
        rdc(OFS_CTLA0, 8'h0C);
        halt = 1'b0;
        end_of_test;
    end
endmodule // tb_top
